// ==== hw/fmbm_channel.sv ====
`timescale 1ns/1ps
module fmbm_channel #(
    parameter int ADC_W = 14
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sample_valid,
    input wire logic [ADC_W-1:0] adc_value,
    input wire logic [ADC_W-1:0] limit,
    input wire logic [1:0] count_select,
    input wire logic restart,
    output logic hit
);
    logic [4:0] exceed_ff;
    logic [4:0] target;
    logic [4:0] nxt_exceed;
    logic over;

    // ==========================================================
    // Target selection
    always_comb begin
        case (count_select)
            fmbm_pkg::CNT_ONE: target = fmbm_pkg::EXCEED_ONE;
            fmbm_pkg::CNT_FOUR: target = fmbm_pkg::EXCEED_FOUR;
            fmbm_pkg::CNT_SIXTEEN: target = fmbm_pkg::EXCEED_SIXTEEN;
            default: target = 5'h00;
        endcase
    end

    assign over = sample_valid && (adc_value > limit);
    assign nxt_exceed = (exceed_ff == 5'h1F) ? exceed_ff : exceed_ff + 5'h01;

    // ==========================================================
    // Exceed counter
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            exceed_ff <= 5'h00;
        end else if (restart) begin
            exceed_ff <= over ? 5'h01 : 5'h00;
        end else if (over) begin
            exceed_ff <= nxt_exceed;
        end
    end

    // Reaches target on this exceedance
    always_comb begin
        hit = over && (count_select != fmbm_pkg::CNT_NEVER) && (nxt_exceed == target);
        if (restart) begin
            hit = over && (target == fmbm_pkg::EXCEED_ONE);
        end
    end
endmodule // fmbm_channel

// ==== hw/fmbm_monitor.sv ====
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module fmbm_monitor #(
    parameter int ADC_W = 14
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic slot_a_sample_valid,
    input wire logic slot_b_sample_valid,
    input wire logic [4*ADC_W-1:0] slot_a_adc,
    input wire logic [4*ADC_W-1:0] slot_b_adc,
    input wire logic float_start,
    output logic [1:0] slot_a_float_emitter_choice,
    output logic [4:0] slot_a_float_pulse_width,
    output logic [7:0] slot_a_float_pulse_delay,
    output logic irq
);
    localparam int NC = fmbm_pkg::NUM_CH;

    logic [15:0] limit_a_ff;
    logic [15:0] limit_b_ff;
    logic [15:0] float_led_a_ff;
    logic [3:0] slot_a_background_flags_ff;
    logic [3:0] slot_b_background_flags_ff;
    logic [7:0] irq_status_ff;
    logic [7:0] irq_mask_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic irq_ff;
    logic [3:0] hit_a;
    logic [3:0] hit_b;
    logic [7:0] hits;
    logic [13:0] slot_a_background_limit;
    logic [13:0] slot_b_background_limit;
    logic [1:0] slot_a_exceed_count_select;
    logic [1:0] slot_b_exceed_count_select;
    logic setup;
    logic wr;
    logic rd;
    logic [9:0] idx;
    logic aligned;
    logic hit_status;
    logic hit_lim_a;
    logic hit_lim_b;
    logic hit_led_a;
    logic hit_irq_st;
    logic hit_irq_mask;
    logic hit_ctrl;
    logic mapped;
    logic status_read;
    logic restart;
    logic ctrl_restart;
    logic [31:0] nxt_prdata;

    // ==========================================================
    // Field extraction
    assign slot_a_background_limit = limit_a_ff[fmbm_pkg::LIMIT_W-1:0];
    assign slot_b_background_limit = limit_b_ff[fmbm_pkg::LIMIT_W-1:0];
    assign slot_a_exceed_count_select = limit_a_ff[fmbm_pkg::CNT_SEL_LSB +: 2];
    assign slot_b_exceed_count_select = limit_b_ff[fmbm_pkg::CNT_SEL_LSB +: 2];

    // ==========================================================
    // APB decode, answer one cycle after setup
    assign setup = psel && !penable && !pready_ff;
    assign wr = setup && pwrite;
    assign rd = setup && !pwrite;
    assign idx = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'h0);

    always_comb begin
        hit_status = 1'b0;
        hit_lim_a = 1'b0;
        hit_lim_b = 1'b0;
        hit_led_a = 1'b0;
        hit_irq_st = 1'b0;
        hit_irq_mask = 1'b0;
        hit_ctrl = 1'b0;
        if (!aligned) begin
            hit_status = 1'b0;
        end else if (idx == {2'h0, fmbm_pkg::IDX_STATUS}) begin
            hit_status = 1'b1;
        end else if (idx == {2'h0, fmbm_pkg::IDX_LIMIT_A}) begin
            hit_lim_a = 1'b1;
        end else if (idx == {2'h0, fmbm_pkg::IDX_LIMIT_B}) begin
            hit_lim_b = 1'b1;
        end else if (idx == {2'h0, fmbm_pkg::IDX_FLOAT_LED_A}) begin
            hit_led_a = 1'b1;
        end else if (idx == {2'h0, fmbm_pkg::IDX_IRQ_STATUS}) begin
            hit_irq_st = 1'b1;
        end else if (idx == {2'h0, fmbm_pkg::IDX_IRQ_MASK}) begin
            hit_irq_mask = 1'b1;
        end else if (idx == {2'h0, fmbm_pkg::IDX_FLOAT_CTRL}) begin
            hit_ctrl = 1'b1;
        end
    end

    assign mapped = hit_status | hit_lim_a | hit_lim_b | hit_led_a | hit_irq_st | hit_irq_mask | hit_ctrl;
    assign status_read = rd && hit_status;
    assign ctrl_restart = wr && hit_ctrl && pwdata[0];
    assign restart = float_start || ctrl_restart || status_read;

    always_comb begin
        nxt_prdata = 32'h0000_0000;
        if (hit_status) begin
            nxt_prdata = {24'h00_0000, slot_b_background_flags_ff, slot_a_background_flags_ff};
        end else if (hit_lim_a) begin
            nxt_prdata = {16'h0000, limit_a_ff};
        end else if (hit_lim_b) begin
            nxt_prdata = {16'h0000, limit_b_ff};
        end else if (hit_led_a) begin
            nxt_prdata = {16'h0000, float_led_a_ff};
        end else if (hit_irq_st) begin
            nxt_prdata = {24'h00_0000, irq_status_ff};
        end else if (hit_irq_mask) begin
            nxt_prdata = {24'h00_0000, irq_mask_ff};
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= setup;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= setup && !mapped;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata_ff <= 32'h0000_0000;
        end else begin
            prdata_ff <= rd ? nxt_prdata : 32'h0000_0000;
        end
    end

    // ==========================================================
    // Writable registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            limit_a_ff <= fmbm_pkg::RST_LIMIT;
        end else if (wr && hit_lim_a) begin
            limit_a_ff <= pwdata[15:0];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            limit_b_ff <= fmbm_pkg::RST_LIMIT;
        end else if (wr && hit_lim_b) begin
            limit_b_ff <= pwdata[15:0];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            float_led_a_ff <= fmbm_pkg::RST_FLOAT_LED_A;
        end else if (wr && hit_led_a) begin
            float_led_a_ff <= pwdata[15:0] & fmbm_pkg::FLOAT_LED_WR_MASK;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_mask_ff <= fmbm_pkg::RST_IRQ_MASK;
        end else if (wr && hit_irq_mask) begin
            irq_mask_ff <= pwdata[7:0];
        end
    end

    // ==========================================================
    // Channel counters
    genvar gi;
    generate
        for (gi = 0; gi < NC; gi++) begin : g_ch
            fmbm_channel #(.ADC_W(ADC_W)) u_a (
                .mclk(mclk),
                .nrst(nrst),
                .sample_valid(slot_a_sample_valid),
                .adc_value(slot_a_adc[gi*ADC_W +: ADC_W]),
                .limit(slot_a_background_limit),
                .count_select(slot_a_exceed_count_select),
                .restart(restart),
                .hit(hit_a[gi])
            );
            fmbm_channel #(.ADC_W(ADC_W)) u_b (
                .mclk(mclk),
                .nrst(nrst),
                .sample_valid(slot_b_sample_valid),
                .adc_value(slot_b_adc[gi*ADC_W +: ADC_W]),
                .limit(slot_b_background_limit),
                .count_select(slot_b_exceed_count_select),
                .restart(restart),
                .hit(hit_b[gi])
            );
        end
    endgenerate

    assign hits = {hit_b, hit_a};

    // ==========================================================
    // Background flags, set wins over read clear
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            slot_a_background_flags_ff <= 4'h0;
        end else if (status_read) begin
            slot_a_background_flags_ff <= hit_a;
        end else begin
            slot_a_background_flags_ff <= slot_a_background_flags_ff | hit_a;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            slot_b_background_flags_ff <= 4'h0;
        end else if (status_read) begin
            slot_b_background_flags_ff <= hit_b;
        end else begin
            slot_b_background_flags_ff <= slot_b_background_flags_ff | hit_b;
        end
    end

    // ==========================================================
    // Interrupt status, write one to clear
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_status_ff <= 8'h00;
        end else if (wr && hit_irq_st) begin
            irq_status_ff <= (irq_status_ff & ~pwdata[7:0]) | hits;
        end else begin
            irq_status_ff <= irq_status_ff | hits;
        end
    end

    // ==========================================================
    // Interrupt output
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_status_ff & irq_mask_ff);
        end
    end

    // ==========================================================
    // Float emitter outputs
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            slot_a_float_emitter_choice <= fmbm_pkg::RST_FLOAT_LED_A[fmbm_pkg::EMITTER_LSB +: 2];
        end else begin
            slot_a_float_emitter_choice <= float_led_a_ff[fmbm_pkg::EMITTER_LSB +: 2];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            slot_a_float_pulse_width <= fmbm_pkg::RST_FLOAT_LED_A[fmbm_pkg::PULSE_WIDTH_LSB +: fmbm_pkg::PULSE_WIDTH_W];
        end else begin
            slot_a_float_pulse_width <= float_led_a_ff[fmbm_pkg::PULSE_WIDTH_LSB +: fmbm_pkg::PULSE_WIDTH_W];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            slot_a_float_pulse_delay <= fmbm_pkg::RST_FLOAT_LED_A[fmbm_pkg::PULSE_DELAY_W-1:0];
        end else begin
            slot_a_float_pulse_delay <= float_led_a_ff[fmbm_pkg::PULSE_DELAY_W-1:0];
        end
    end

    // ==========================================================
    // Register outputs
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
endmodule // fmbm_monitor

// ==== hw/fmbm_pkg.sv ====
package fmbm_pkg;
    // ==========================================================
    // Register indices (printed offsets), byte address = 4 * index
    localparam logic [7:0] IDX_STATUS = 8'h04;
    localparam logic [7:0] IDX_LIMIT_A = 8'h16;
    localparam logic [7:0] IDX_LIMIT_B = 8'h1C;
    localparam logic [7:0] IDX_FLOAT_LED_A = 8'h3E;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h60;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h61;
    localparam logic [7:0] IDX_FLOAT_CTRL = 8'h62;

    // ==========================================================
    // Field positions
    localparam int CNT_SEL_LSB = 14;
    localparam int LIMIT_W = 14;
    localparam int PULSE_WIDTH_LSB = 8;
    localparam int PULSE_WIDTH_W = 5;
    localparam int PULSE_DELAY_W = 8;
    localparam int EMITTER_LSB = 14;
    localparam int REG_W = 16;
    localparam int NUM_CH = 4;
    localparam int EXCEED_W = 5;
    localparam logic [15:0] FLOAT_LED_WR_MASK = 16'hDFFF;

    // ==========================================================
    // Reset values
    localparam logic [15:0] RST_LIMIT = 16'h0000;
    localparam logic [15:0] RST_FLOAT_LED_A = 16'h0320;
    localparam logic [7:0] RST_IRQ_MASK = 8'h00;

    // ==========================================================
    // Exceed count codes
    localparam logic [1:0] CNT_NEVER = 2'h0;
    localparam logic [1:0] CNT_ONE = 2'h1;
    localparam logic [1:0] CNT_FOUR = 2'h2;
    localparam logic [1:0] CNT_SIXTEEN = 2'h3;
    localparam logic [4:0] EXCEED_ONE = 5'h01;
    localparam logic [4:0] EXCEED_FOUR = 5'h04;
    localparam logic [4:0] EXCEED_SIXTEEN = 5'h10;
endpackage

// ==== testbench/fmbm_monitor_chk.sv ====
`timescale 1ns/1ps
module fmbm_monitor_chk (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] slot_a_float_emitter_choice,
    input wire logic [4:0] slot_a_float_pulse_width,
    input wire logic [7:0] slot_a_float_pulse_delay,
    input wire logic irq
);
    // ==========================================
    // Shadow of float setup and mask state
    logic [15:0] led_ff;
    logic mask_zero_ff;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            led_ff <= 16'h0320;
            mask_zero_ff <= 1'b1;
        end else if (psel && penable && pready && pwrite) begin
            if (paddr == 12'h0F8) led_ff <= pwdata[15:0];
            if (paddr == 12'h184) mask_zero_ff <= (pwdata[7:0] == 8'h00);
        end
    end
    // ==========================================
    // Properties
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence led_write_s;
        psel && penable && pready && pwrite && paddr == 12'h0F8;
    endsequence
    ready_time_a: assert property (setup_s |=> pready) else $error("no answer after setup");
    ready_phase_a: assert property (pready |-> psel && penable) else $error("ready outside access");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
    err_decode_a: assert property (pready |-> pslverr == !(paddr inside {12'h010, 12'h058, 12'h070,
        12'h0F8, 12'h180, 12'h184, 12'h188})) else $error("error flag wrong for address");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
    status_hi_zero_a: assert property (pready && !pwrite && paddr == 12'h010 |-> prdata[31:8] == 24'h0)
        else $error("status upper bits not zero");
    led_fields_a: assert property (led_write_s ##3 1'b1 |->
        {slot_a_float_emitter_choice, slot_a_float_pulse_width, slot_a_float_pulse_delay}
        == {led_ff[15:14], led_ff[12:0]}) else $error("float outputs differ from register");
    irq_masked_a: assert property (mask_zero_ff && $past(mask_zero_ff) && $past(mask_zero_ff, 2) |-> !irq)
        else $error("interrupt while all masked");
endmodule // fmbm_monitor_chk

bind fmbm_monitor fmbm_monitor_chk fmbm_monitor_chk_i (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slot_a_float_emitter_choice(slot_a_float_emitter_choice), .slot_a_float_pulse_width(slot_a_float_pulse_width),
    .slot_a_float_pulse_delay(slot_a_float_pulse_delay), .irq(irq));

// ==== testbench/fmbm_monitor_test.sv ====
`timescale 1ns/1ps
module fmbm_monitor_test;
    logic mclk, nrst, psel, penable, pwrite, sva, svb, fstart, pready, pslverr, irq, err_v;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic [55:0] adc_a, adc_b;
    logic [1:0] choice;
    logic [4:0] width;
    logic [7:0] delay;
    int err_total, checked, cyc;
    fmbm_monitor fmbm_monitor_i (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slot_a_sample_valid(sva), .slot_b_sample_valid(svb), .slot_a_adc(adc_a), .slot_b_adc(adc_b),
        .float_start(fstart), .slot_a_float_emitter_choice(choice), .slot_a_float_pulse_width(width),
        .slot_a_float_pulse_delay(delay), .irq(irq));
    // ==========================================
    // Clock, timeout, helpers
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (err_total == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd_v, e);
    endtask
    task automatic samp(input int s, input int ch, input logic [13:0] v, input int n);
        repeat (n) begin
            @(posedge mclk);
            adc_a <= 56'(v) << (14 * ch);
            adc_b <= 56'(v) << (14 * ch);
            sva <= (s == 0);
            svb <= (s == 1);
            @(posedge mclk);
            sva <= 1'b0;
            svb <= 1'b0;
        end
    endtask
    // ==========================================
    // Scenarios
    task automatic t_regs();
        chk({17'h0, choice, width, delay}, 32'h0320);
        rd(12'h0F8, 32'h0320);
        rd(12'h058, 32'h0);
        rd(12'h070, 32'h0);
        rd(12'h188, 32'h0);
        apb(1'b1, 12'h058, 32'hFFFFFFFF);
        rd(12'h058, 32'h0000FFFF);
        apb(1'b1, 12'h070, 32'h0000C123);
        rd(12'h070, 32'h0000C123);
        apb(1'b1, 12'h0F8, 32'hFFFFFFFF);
        rd(12'h0F8, 32'h0000DFFF);
        chk({17'h0, choice, width, delay}, 32'h7FFF);
        apb(1'b1, 12'h0F8, 32'h4305);
        repeat (3) @(posedge mclk);
        chk({17'h0, choice, width, delay}, 32'h2305);
        apb(1'b0, 12'h040, 32'h0);
        chk({31'h0, err_v}, 32'h1);
        apb(1'b1, 12'h059, 32'h0);
        chk({31'h0, err_v}, 32'h1);
    endtask
    task automatic t_count();
        int need [4] = '{16, 1, 4, 16};
        logic [31:0] flag;
        for (int s = 0; s < 2; s++) begin
            for (int c = 0; c < 4; c++) begin
                flag = (c == 0) ? 32'h0 : 32'h1 << (s * 4 + c);
                apb(1'b1, s ? 12'h070 : 12'h058, {16'h0, 2'(c), 14'h0100});
                samp(s, c, 14'h0101, need[c] - 1);
                rd(12'h010, 32'h0);
                samp(s, c, 14'h0101, need[c] - 1);
                rd(12'h010, 32'h0);
                samp(s, c, 14'h0101, need[c] - 1);
                @(posedge mclk);
                fstart <= 1'b1;
                @(posedge mclk);
                fstart <= 1'b0;
                samp(s, c, 14'h0100, 2);
                samp(s, c, 14'h0101, need[c] - 1);
                rd(12'h010, 32'h0);
                samp(s, c, 14'h0101, need[c] - 1);
                apb(1'b1, 12'h188, 32'h1);
                samp(s, c, 14'h0101, need[c] - 1);
                rd(12'h010, 32'h0);
                samp(s, c, 14'h0101, need[c]);
                apb(1'b1, 12'h010, 32'h0);
                rd(12'h010, flag);
                rd(12'h010, 32'h0);
            end
        end
    endtask
    task automatic t_irq();
        apb(1'b1, 12'h180, 32'hFF);
        apb(1'b1, 12'h058, 32'h4100);
        samp(0, 0, 14'h0101, 1);
        rd(12'h010, 32'h1);
        rd(12'h180, 32'h1);
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 12'h184, 32'h1);
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 12'h180, 32'h1);
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
    endtask
    initial begin
        {nrst, psel, penable, pwrite, sva, svb, fstart} = 7'h00;
        {paddr, pwdata, adc_a, adc_b} = 156'h0;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        t_regs();
        t_count();
        t_irq();
        report_and_stop();
    end
endmodule // fmbm_monitor_test
